// ### rtl/dbp_pointer.sv
`timescale 1ns/100ps
`include "dbp_regs.svh"
module dbp_pointer
  import dbp_pkg::*;
#(
  // Area start, bits 31:12: a component's final page or the directory table
  parameter logic [19:0] ADDR_FIELD = 20'h80000,
  parameter bit ENTRY_PRESENT = 1'b1,
  parameter bit SEGMENTED = 1'b1
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Access port register access
  input wire logic SEL,
  input wire logic WRITE,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  output logic [31:0] RDATA,
  output logic ACK,
  // Debug link address segmentation
  input wire logic [31:0] LINK_ADDR,
  input wire logic LINK_FROM_DEBUGGER,
  output logic [30:0] LINK_SEG_ADDR,
  output logic LINK_DEBUG_SEG
);
  dbp_value_if val ();
  dbp_word_t rdata_d;
  logic hit;
  logic unused_wdata;

  // Bank and word select, and the request kind
  logic [3:0] bank_sel;
  logic [1:0] word_sel;
  logic byte_ok;
  logic rd_req;
  logic wr_req;

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  // Offset macros must agree with the bank and word split
  if (`DBP_PTR_OFFSET != {`DBP_PTR_BANK, `DBP_PTR_WORD, 2'h0}) begin : g_bad_offset
    $error("Pointer offset does not match its bank and word");
  end
  // The address field must fill its bit positions exactly
  if (`DBP_ADDR_MSB - `DBP_ADDR_LSB + 1 != $bits(dbp_field_t)) begin : g_bad_field
    $error("Address field width does not match its positions");
  end

  dbp_value #(
    .ADDR_FIELD(ADDR_FIELD),
    .ENTRY_PRESENT(ENTRY_PRESENT),
    .SEGMENTED(SEGMENTED)
  ) u_value (
    .v(val.src)
  );

  // ----------------------------------------
  // Register read path
  // ----------------------------------------
  // Bank in bits 7:4, word in bits 3:2; a byte offset inside a word misses
  assign bank_sel = ADDR[7:4];
  assign word_sel = ADDR[3:2];
  assign byte_ok = (ADDR[1:0] == 2'h0);
  assign hit = byte_ok && (bank_sel == `DBP_PTR_BANK) && (word_sel == `DBP_PTR_WORD);
  assign rd_req = SEL && !WRITE;
  assign wr_req = SEL && WRITE;
  assign unused_wdata = ^WDATA;

  always_comb begin
    rdata_d = `DBP_RESET_DATA;
    if (rd_req && hit) begin
      rdata_d = val.value;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= `DBP_RESET_DATA;
    end else begin
      RDATA <= rdata_d;
    end
  end

  // Every access is acknowledged next cycle; writes store nothing
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ACK <= 1'b0;
    end else begin
      ACK <= SEL;
    end
  end

  // ----------------------------------------
  // Segmentation of the dedicated link
  // ----------------------------------------
  // Both halves alias the same registers; top bit tags debugger access
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      LINK_SEG_ADDR <= 31'h0;
      LINK_DEBUG_SEG <= 1'b0;
    end else begin
      LINK_SEG_ADDR <= LINK_ADDR[30:0];
      LINK_DEBUG_SEG <= LINK_ADDR[31] | LINK_FROM_DEBUGGER;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_ptr_read;
    SEL && !WRITE && hit;
  endsequence

  a_ptr_read_value: assert property (@(posedge CLK) disable iff (RESET)
    s_ptr_read |=> RDATA == val.value)
    else $error("pointer read returned wrong value");
  a_format_bit_set: assert property (@(posedge CLK) disable iff (RESET)
    s_ptr_read |=> RDATA[`DBP_FMT_BIT])
    else $error("format bit not set");
  a_present_bit_val: assert property (@(posedge CLK) disable iff (RESET)
    s_ptr_read |=> RDATA[`DBP_PRESENT_BIT] == ENTRY_PRESENT)
    else $error("present bit wrong");
  a_reserved_zero: assert property (@(posedge CLK) disable iff (RESET)
    s_ptr_read |=> RDATA[11:2] == 10'h000 && RDATA[31:12] == ADDR_FIELD)
    else $error("address field or reserved bits wrong");
  a_no_old_format: assert property (@(posedge CLK) disable iff (RESET)
    s_ptr_read |=> RDATA != `DBP_NO_ENTRIES_VALUE)
    else $error("older encoding produced");
  a_write_no_data: assert property (@(posedge CLK) disable iff (RESET)
    SEL && WRITE |=> RDATA == 32'h00000000 && ACK)
    else $error("write produced read data");
  a_segment_top: assert property (@(posedge CLK) disable iff (RESET)
    (s_ptr_read and (SEGMENTED == 1'b1)) |=> RDATA[31])
    else $error("segmented link without top bit");
  a_segment_alias: assert property (@(posedge CLK) disable iff (RESET)
    LINK_ADDR[31] |=> LINK_DEBUG_SEG && LINK_SEG_ADDR == $past(LINK_ADDR[30:0]))
    else $error("debugger half not recognised");

  // ----------------------------------------
  // Access sequences
  // ----------------------------------------
  // Write to any offset, the pointer included
  sequence s_any_write;
    wr_req;
  endsequence

  // Read of an offset that holds no register here
  sequence s_other_read;
    rd_req && !hit;
  endsequence

  // Edge with no request on the port
  sequence s_no_request;
    !SEL;
  endsequence

  // Pointer write, then a pointer read on the next edge
  sequence s_write_then_read;
    wr_req && hit ##1 s_ptr_read;
  endsequence

  // Two pointer reads on consecutive edges
  sequence s_read_pair;
    s_ptr_read ##1 s_ptr_read;
  endsequence

  // Pointer read followed by an idle edge
  sequence s_read_then_idle;
    s_ptr_read ##1 s_no_request;
  endsequence

  // Unmapped read, then a pointer read two edges later, with any request between
  sequence s_other_then_ptr;
    s_other_read ##2 s_ptr_read;
  endsequence

  // Write followed by an idle edge
  sequence s_write_then_idle;
    s_any_write ##1 s_no_request;
  endsequence

  // Debugger half marked by the address bit alone
  sequence s_debug_half;
    LINK_ADDR[31] && !LINK_FROM_DEBUGGER;
  endsequence

  // Link access in the system half with no debugger flag
  sequence s_system_half;
    !LINK_ADDR[31] && !LINK_FROM_DEBUGGER;
  endsequence

  // ----------------------------------------
  // Port and link properties
  // ----------------------------------------
  // Pointer word rebuilt from its fields for comparison
  localparam dbp_word_t EXP_WORD = {ADDR_FIELD, 12'h000} | 32'h00000002 | {31'h0, ENTRY_PRESENT};

  // Every taken request is answered on the next edge
  property p_ack_follows;
    @(posedge CLK) disable iff (RESET)
    SEL |=> ACK;
  endproperty
  a_ack_follows_sel: assert property (p_ack_follows)
    else $error("request not acknowledged");

  // No answer without a request
  property p_ack_idle;
    @(posedge CLK) disable iff (RESET)
    s_no_request |=> !ACK;
  endproperty
  a_ack_idle_low: assert property (p_ack_idle)
    else $error("acknowledge without request");

  // Offsets that hold nothing read zero
  property p_other_zero;
    @(posedge CLK) disable iff (RESET)
    s_other_read |=> ACK && RDATA == `DBP_RESET_DATA;
  endproperty
  a_other_reads_zero: assert property (p_other_zero)
    else $error("unmapped offset read nonzero");

  // A write just before a read leaves the pointer unchanged
  property p_write_ignored;
    @(posedge CLK) disable iff (RESET)
    s_write_then_read |=> ACK && RDATA == EXP_WORD;
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("write altered the pointer");

  // A read answer stands for one cycle only
  property p_answer_once;
    @(posedge CLK) disable iff (RESET)
    s_read_then_idle |=> !ACK && RDATA == `DBP_RESET_DATA;
  endproperty
  a_answer_one_cycle: assert property (p_answer_once)
    else $error("read answer held too long");

  // Back to back reads return the same constant word
  property p_read_repeat;
    @(posedge CLK) disable iff (RESET)
    s_read_pair |=> RDATA == EXP_WORD && $past(RDATA) == EXP_WORD;
  endproperty
  a_read_repeat_same: assert property (p_read_repeat)
    else $error("pointer changed between reads");

  // An unmapped read leaves no trace on a later pointer read
  property p_other_then_ptr;
    @(posedge CLK) disable iff (RESET)
    s_other_then_ptr |=> RDATA == EXP_WORD;
  endproperty
  a_other_then_ptr: assert property (p_other_then_ptr)
    else $error("pointer wrong after unmapped read");

  // A write leaves nothing behind once answered
  property p_write_quiet;
    @(posedge CLK) disable iff (RESET)
    s_write_then_idle |=> !ACK && RDATA == `DBP_RESET_DATA;
  endproperty
  a_write_leaves_nothing: assert property (p_write_quiet)
    else $error("write left an answer behind");

  // The top address bit alone selects the debugger half
  property p_debug_half;
    @(posedge CLK) disable iff (RESET)
    s_debug_half |=> LINK_DEBUG_SEG;
  endproperty
  a_debugger_half: assert property (p_debug_half)
    else $error("address bit did not mark debugger");

  // System half keeps its offset and is not marked
  property p_system_half;
    @(posedge CLK) disable iff (RESET)
    s_system_half |=> !LINK_DEBUG_SEG && LINK_SEG_ADDR == $past(LINK_ADDR[30:0]);
  endproperty
  a_system_half: assert property (p_system_half)
    else $error("system half access mismarked");

  // The debugger flag forces the debugger half
  property p_debug_flag;
    @(posedge CLK) disable iff (RESET)
    LINK_FROM_DEBUGGER |=> LINK_DEBUG_SEG;
  endproperty
  a_debugger_flag: assert property (p_debug_flag)
    else $error("debugger flag not honoured");

  // Each reserved bit of an answered pointer read is zero
  for (genvar b = `DBP_FMT_BIT + 1; b < `DBP_ADDR_LSB; b++) begin : g_reserved
    a_reserved_bit: assert property (@(posedge CLK) disable iff (RESET)
      s_ptr_read |=> !RDATA[b])
      else $error("reserved bit set");
  end
endmodule // dbp_pointer

// ### rtl/dbp_regs.svh
`ifndef DBP_REGS_SVH
`define DBP_REGS_SVH

// Register placement within the access port space
`define DBP_PTR_OFFSET 8'hF8
`define DBP_PTR_BANK 4'hF
`define DBP_PTR_WORD 2'h2

// Field positions
`define DBP_ADDR_MSB 31
`define DBP_ADDR_LSB 12
`define DBP_FMT_BIT 1
`define DBP_PRESENT_BIT 0

// Constant values
`define DBP_FMT_CURRENT 1'h1
`define DBP_NO_ENTRIES_VALUE 32'hFFFFFFFF
`define DBP_RESET_DATA 32'h00000000

`endif

// ### rtl/dbp_pkg.sv
package dbp_pkg;
  typedef logic [31:0] dbp_word_t;
  typedef logic [19:0] dbp_field_t;
  typedef enum logic {DBP_RD, DBP_WR} dbp_dir_t;
endpackage

// ### rtl/dbp_value_if.sv
`timescale 1ns/100ps
interface dbp_value_if;
  import dbp_pkg::*;
  dbp_word_t value;
  modport src (output value);
  modport dst (input value);
endinterface // dbp_value_if

// ### rtl/dbp_value.sv
`timescale 1ns/100ps
`include "dbp_regs.svh"
module dbp_value
  import dbp_pkg::*;
#(
  parameter logic [19:0] ADDR_FIELD = 20'h80000,
  parameter bit ENTRY_PRESENT = 1'b1,
  parameter bit SEGMENTED = 1'b1
) (
  dbp_value_if.src v
);
  // Refused at elaboration: a segmented link needs the debugger half
  if (SEGMENTED && !ADDR_FIELD[19]) begin : g_bad_segment
    $error("Segmented link needs the top address bit set");
  end

  // Pointer word: address field, zero reserved bits, format, present
  assign v.value = {ADDR_FIELD, 10'h000, `DBP_FMT_CURRENT, ENTRY_PRESENT};
endmodule // dbp_value

// ### tb/dbp_debugger.sv
`timescale 1ns/100ps
module dbp_debugger
  import dbp_pkg::*;
(
  // Pointer word in, decoded view out
  input wire dbp_word_t word,
  input wire logic id_fault,
  output logic present,
  output logic legacy,
  output logic warn,
  output dbp_word_t base,
  output dbp_word_t id_addr
);
  always_comb begin
    present = (word != 32'hFFFFFFFF) && (!word[1] || word[0]);
    legacy = !word[1];
    warn = present && id_fault;
    base = {word[31:12], 12'h000};
    id_addr = {word[31:12], 12'hFF0};
  end
endmodule // dbp_debugger

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import dbp_pkg::*;
  localparam dbp_word_t PTR = 32'h80000003;
  logic CLK = 0, RESET = 1, SEL = 0, WRITE = 0, LINK_FROM_DEBUGGER = 0, ACK, SEG, present;
  logic [7:0] ADDR = 8'h00;
  logic [30:0] SEG_ADDR;
  logic legacy, warn, id_fault = 0;
  dbp_word_t id_addr;
  dbp_word_t WDATA = 32'h0, LINK_ADDR = 32'h0, RDATA, ptr = 32'h0, base;
  int err_total = 0, check_count = 0;
  initial forever #2.5 CLK = ~CLK;
  dbp_pointer u_dbp_pointer (.CLK(CLK), .RESET(RESET), .SEL(SEL), .WRITE(WRITE),
    .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .ACK(ACK), .LINK_ADDR(LINK_ADDR),
    .LINK_FROM_DEBUGGER(LINK_FROM_DEBUGGER), .LINK_SEG_ADDR(SEG_ADDR),
    .LINK_DEBUG_SEG(SEG));
  dbp_debugger u_dbp_debugger (.word(ptr), .id_fault(id_fault), .present(present),
    .legacy(legacy), .warn(warn), .base(base), .id_addr(id_addr));
  // ----------------
  // Bus tasks
  // ----------------
  task automatic check(input string name, input dbp_word_t exp, input dbp_word_t got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic access(input logic wr, input logic [7:0] a, input dbp_word_t exp);
    @(negedge CLK);
    SEL = 1;
    WRITE = wr;
    ADDR = a;
    WDATA = 32'hA5A5A5A5;
    @(negedge CLK);
    SEL = 0;
    check("ack", 32'h1, 32'(ACK));
    check("rdata", exp, RDATA);
    ptr = RDATA;
  endtask
  task automatic close_out;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------
  // Sequence
  // ----------------
  initial begin
    #20000;
    err_total++;
    close_out;
  end
  initial begin
    repeat (4) @(negedge CLK);
    RESET = 0;
    access(0, 8'hF8, PTR);
    @(negedge CLK);
    check("present", 32'h1, 32'(present));
    check("base", 32'h80000000, base);
    check("id addr", 32'h80000FF0, id_addr);
    check("format", 32'h0, 32'(legacy));
    check("no warn", 32'h0, 32'(warn));
    check("ack idle", 32'h0, 32'(ACK));
    check("rdata idle", 32'h0, RDATA);
    access(1, 8'hF8, 32'h0);
    access(0, 8'hF4, 32'h0);
    access(0, 8'hF8, PTR);
    @(negedge CLK);
    SEL = 1;
    WRITE = 1;
    ADDR = 8'hF8;
    @(negedge CLK);
    WRITE = 0;
    check("wr rdata", 32'h0, RDATA);
    @(negedge CLK);
    check("rd after wr", PTR, RDATA);
    @(negedge CLK);
    SEL = 0;
    check("rd pair", PTR, RDATA);
    @(negedge CLK);
    check("rd released", 32'h0, RDATA);
    ptr = 32'hFFFFFFFF;
    #1;
    check("old absent", 32'h0, 32'(present));
    ptr = 32'h12345000;
    id_fault = 1;
    #1;
    check("old present", 32'h1, 32'(present));
    check("old format", 32'h1, 32'(legacy));
    check("old base", 32'h12345000, base);
    check("id warn", 32'h1, 32'(warn));
    for (int i = 0; i < 3; i++) begin
      @(negedge CLK);
      LINK_ADDR = {i[0], 31'h12345678};
      LINK_FROM_DEBUGGER = i[1];
      @(negedge CLK);
      check("seg", 32'(i[0] | i[1]), 32'(SEG));
      check("seg addr", 32'h12345678, 32'(SEG_ADDR));
    end
    close_out;
  end
endmodule // testbench
